// ---- hw/dftc_top.sv ----
// dma fifo test and bus option register bank behind an axi4-lite slave
`timescale 1ns/10ps
module dftc_top #(
  parameter longint SEL_TIMEOUT = dftc_pkg::SEL_TIMEOUT_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              bus_master,
  input  wire logic              sync_mode,
  input  wire logic              burst_ok,
  input  wire logic              host_cycle_req,
  input  wire logic              gross_error,
  input  wire logic              core_move,
  input  wire logic              sel_active,
  input  wire logic              call_load,
  input  wire logic              mem_move,
  input  wire logic [31:0]       return_addr,
  output logic                   sel_timeout,
  output logic                   pointer_load,
  output logic [31:0]            pointer_value,
  output dftc_pkg::dftc_pins_s   pins,
  output dftc_pkg::dftc_hs_s     hs
);
  // pin inputs pass two flops before use
  logic [8:0] sync1_q, sync2_q;
  wire  [8:0] raw_in = {bus_master, sync_mode, burst_ok, host_cycle_req, gross_error,
                        core_move, sel_active, call_load, mem_move};
  wire m_own  = sync2_q[8];
  wire m_sync = sync2_q[7];
  wire m_bok  = sync2_q[6];
  wire m_hcr  = sync2_q[5];
  wire m_gerr = sync2_q[4];
  wire m_move = sync2_q[3];
  wire m_sel  = sync2_q[2];
  wire m_call = sync2_q[1];
  wire m_mm   = sync2_q[0];
  logic [31:0] ret_s1_q, ret_s2_q;

  logic [7:0]  t4_q, hs_q, opt_q, t2_q, t8_q;
  logic [31:0] stack_q, next_q;
  logic [23:0] count_q;
  logic [6:0]  off_q;
  logic [7:0]  lane_d_q [dftc_pkg::DEPTH];
  logic        lane_p_q [dftc_pkg::DEPTH];
  logic [3:0]  lane_full_q;
  logic        dir_q, last_q, req_q, grant_q;
  logic [31:0] tmo_q;
  logic        aw_q, w_q;
  logic [31:0] awaddr_q, wdata_q;
  logic [3:0]  wstrb_q;

  function automatic logic [7:0] word_idx(input logic [31:0] a);
    word_idx = a[9:2];
  endfunction
  function automatic logic known(input logic [7:0] i);
    known = (i == dftc_pkg::IDX_TEST_REG_FOUR) || (i == dftc_pkg::IDX_HANDSHAKE) ||
            (i == dftc_pkg::IDX_FIFO_PORT) || (i == dftc_pkg::IDX_BUS_OPTION) ||
            (i == dftc_pkg::IDX_CALL_STACK) || (i == dftc_pkg::IDX_XFER_OFFSET) ||
            (i == dftc_pkg::IDX_INT_STATE) || (i == dftc_pkg::IDX_TEST_REG_TWO) ||
            (i == dftc_pkg::IDX_TEST_REG_EIGHT) || (i == dftc_pkg::IDX_BYTE_COUNTER) ||
            (i == dftc_pkg::IDX_NEXT_DATA) || (i == dftc_pkg::IDX_OFFSET_CNT) ||
            (i == dftc_pkg::IDX_GROSS_ERROR);
  endfunction

  // write side: address and data may arrive in either order
  wire         wr_fire = aw_q && w_q && !s_axi_bvalid;
  wire  [7:0]  wr_idx  = word_idx(awaddr_q);
  wire  [7:0]  wb      = wstrb_q[0] ? wdata_q[7:0] : 8'h00;
  wire         wr_b0   = wr_fire && wstrb_q[0];
  wire         wr_hs   = wr_b0 && (wr_idx == dftc_pkg::IDX_HANDSHAKE);
  wire         lane_en = t4_q[2];
  wire  [1:0]  lane    = t4_q[1:0];
  wire         wr_fifo = wr_b0 && (wr_idx == dftc_pkg::IDX_FIFO_PORT) && lane_en;
  wire         master  = hs_q[dftc_pkg::HS_MASTER];
  wire         rd_fire = s_axi_arvalid && s_axi_arready;
  wire  [7:0]  rd_idx  = word_idx(s_axi_araddr);
  wire         rd_fifo = rd_fire && (rd_idx == dftc_pkg::IDX_FIFO_PORT) && lane_en;
  wire         f_full  = lane_full_q[lane];

  // override bits latch the chosen level only while written as one
  wire set_dir   = wr_hs && wb[dftc_pkg::HS_DIR];
  wire set_last  = wr_hs && wb[dftc_pkg::HS_LAST];
  wire set_req   = wr_hs && wb[dftc_pkg::HS_REQ];
  wire set_grant = wr_hs && wb[dftc_pkg::HS_GRANT];
  wire step_addr = hs_q[dftc_pkg::HS_ADDR_STEP];
  wire step_cnt  = hs_q[dftc_pkg::HS_COUNT_STEP];
  wire off_clr   = hs_q[dftc_pkg::HS_OFF_RESET];
  // bottom byte of the selected lane
  wire  [7:0] fbyte  = lane_d_q[lane];

  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h00000000;
    unique case (rd_idx)
      dftc_pkg::IDX_TEST_REG_FOUR:  rmux = {24'h0, t4_q & dftc_pkg::T4_MASK};
      dftc_pkg::IDX_HANDSHAKE:      rmux = {24'h0, hs_q};
      dftc_pkg::IDX_FIFO_PORT:      rmux = {24'h0, lane_en ? fbyte : 8'h00};
      dftc_pkg::IDX_BUS_OPTION:     rmux = {24'h0, opt_q};
      dftc_pkg::IDX_CALL_STACK:     rmux = stack_q;
      dftc_pkg::IDX_XFER_OFFSET:    rmux = {25'h0, off_q};
      dftc_pkg::IDX_TEST_REG_TWO:   rmux = {24'h0, t2_q[7:4], t2_q[3], 1'b0, req_q, ~grant_q};
      dftc_pkg::IDX_TEST_REG_EIGHT: rmux = {24'h0, t8_q & dftc_pkg::T8_MASK};
      dftc_pkg::IDX_BYTE_COUNTER:   rmux = {8'h0, count_q};
      dftc_pkg::IDX_NEXT_DATA:      rmux = next_q;
      dftc_pkg::IDX_OFFSET_CNT:     rmux = {25'h0, (off_q - count_q[6:0]) & dftc_pkg::OFFSET_MSK};
      default:                      rmux = 32'h00000000;
    endcase
  end
  wire rd_ok = known(rd_idx);
  // host parity per lane of the read word
  wire [3:0] rd_par;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_par
      assign rd_par[g] = (~^rmux[8*g +: 8]) ^ opt_q[dftc_pkg::BO_PAR_SENSE];
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_q <= 9'h000;
      sync2_q <= 9'h000;
      ret_s1_q <= dftc_pkg::RST_WORD;
      ret_s2_q <= dftc_pkg::RST_WORD;
    end else if (clk_en) begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
      ret_s1_q <= return_addr;
      ret_s2_q <= ret_s1_q;
    end
  end

  // axi handshake
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= dftc_pkg::RST_WORD;
      wdata_q <= dftc_pkg::RST_WORD;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dftc_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= dftc_pkg::RST_WORD;
      s_axi_rresp <= dftc_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= !aw_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= known(wr_idx) ? dftc_pkg::RESP_OKAY : dftc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rmux;
        s_axi_rresp <= rd_ok ? dftc_pkg::RESP_OKAY : dftc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // register bank and core state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      t4_q <= dftc_pkg::RST_BYTE;
      hs_q <= dftc_pkg::RST_BYTE;
      opt_q <= dftc_pkg::RST_BYTE;
      t2_q <= dftc_pkg::RST_T2;
      t8_q <= dftc_pkg::RST_BYTE;
      stack_q <= dftc_pkg::RST_WORD;
      next_q <= dftc_pkg::RST_WORD;
      count_q <= 24'h000000;
      off_q <= 7'h00;
      dir_q <= 1'b0;
      last_q <= 1'b0;
      req_q <= 1'b0;
      grant_q <= 1'b0;
      lane_full_q <= 4'h0;
      for (int i = 0; i < dftc_pkg::DEPTH; i++) begin
        lane_d_q[i] <= 8'h00;
        lane_p_q[i] <= 1'b0;
      end
    end else if (clk_en) begin
      // step and pulse bits clear on the same edge they act; the offset reset bit reloads the synced gross error
      hs_q[dftc_pkg::HS_ADDR_STEP] <= 1'b0;
      hs_q[dftc_pkg::HS_COUNT_STEP] <= 1'b0;
      hs_q[dftc_pkg::HS_OFF_RESET] <= m_gerr;
      if (master) begin
        hs_q[dftc_pkg::HS_LAST] <= 1'b0;
        hs_q[dftc_pkg::HS_REQ] <= 1'b0;
        hs_q[dftc_pkg::HS_GRANT] <= 1'b0;
        last_q <= 1'b0;
      end
      if (step_addr) next_q <= next_q + dftc_pkg::ADDR_STEP;
      // counter cannot wrap below zero; the pointer supplies the step alignment
      if (step_cnt) count_q <= (count_q >= dftc_pkg::CNT_STEP - {22'h0, next_q[1:0]}) ?
                                count_q - (dftc_pkg::CNT_STEP - {22'h0, next_q[1:0]}) :
                                24'h000000;
      if (off_clr) off_q <= 7'h00;
      else if (m_move) off_q <= off_q + 7'h01;
      if (m_call) stack_q <= ret_s2_q;
      else if (m_mm) stack_q <= ~stack_q;
      if (wr_b0) begin
        unique case (wr_idx)
          dftc_pkg::IDX_TEST_REG_FOUR:  t4_q <= wb & dftc_pkg::T4_MASK;
          dftc_pkg::IDX_HANDSHAKE:      hs_q <= wb | {2'b00, m_gerr, 5'h00};
          dftc_pkg::IDX_BUS_OPTION:     opt_q <= wb;
          dftc_pkg::IDX_XFER_OFFSET:    off_q <= wb[6:0];
          dftc_pkg::IDX_TEST_REG_EIGHT: t8_q <= wb & dftc_pkg::T8_MASK;
          // a pending gross error keeps the clear request set
          dftc_pkg::IDX_GROSS_ERROR:    hs_q[dftc_pkg::HS_OFF_RESET] <= wb[0] | m_gerr;
          default: ;
        endcase
      end
      if (wr_fire && wr_idx == dftc_pkg::IDX_CALL_STACK) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_q[b]) stack_q[8*b +: 8] <= wdata_q[8*b +: 8];
        end
      end
      if (wr_fire && wr_idx == dftc_pkg::IDX_BYTE_COUNTER) count_q <= wdata_q[23:0];
      if (wr_fire && wr_idx == dftc_pkg::IDX_NEXT_DATA) next_q <= wdata_q;
      if (set_dir) dir_q <= master;
      if (set_last) last_q <= master;
      if (set_req) req_q <= master;
      if (set_grant) grant_q <= master;
      // single-entry lanes: a load over a full lane overwrites the top
      if (wr_fifo) begin
        lane_d_q[lane] <= wb;
        lane_p_q[lane] <= opt_q[dftc_pkg::BO_FIFO_PAR];
        lane_full_q[lane] <= 1'b1;
      end else if (rd_fifo) begin
        lane_full_q[lane] <= 1'b0;
      end
      if (rd_fifo) t2_q[dftc_pkg::T2_FIFO_PAR] <= f_full ? lane_p_q[lane] : 1'b0;
    end
  end

  // selection timer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tmo_q <= dftc_pkg::RST_WORD;
      sel_timeout <= 1'b0;
    end else if (clk_en) begin
      if (!m_sel || opt_q[dftc_pkg::BO_TMO_DIS]) begin
        tmo_q <= dftc_pkg::RST_WORD;
        sel_timeout <= 1'b0;
      end else if (tmo_q == 32'(SEL_TIMEOUT - 1)) begin
        sel_timeout <= 1'b1;
      end else begin
        tmo_q <= tmo_q + 32'h00000001;
      end
    end
  end

  // pins and internal handshake outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pins <= '0;
      hs <= '0;
      pointer_load <= 1'b0;
      pointer_value <= dftc_pkg::RST_WORD;
    end else if (clk_en) begin
      pins.burst_req <= m_own && m_sync && m_bok && !opt_q[dftc_pkg::BO_BURST_DIS];
      pins.snoop_hi  <= m_own && opt_q[dftc_pkg::BO_SNOOP_HI];
      pins.snoop_lo  <= m_own && (t8_q[0] ? m_hcr : opt_q[dftc_pkg::BO_SNOOP_LO]);
      pins.xfer_type <= m_own && m_sync && opt_q[dftc_pkg::BO_XFER_TYPE];
      pins.balanced  <= opt_q[dftc_pkg::BO_BALANCED];
      pins.host_par  <= lane_p_q[lane] ^ opt_q[dftc_pkg::BO_PAR_SENSE];
      // lane parity launched with the read data, so both stand together
      if (rd_fire) pins.read_par <= rd_par;
      hs.dir   <= dir_q;
      hs.last  <= last_q;
      hs.req   <= req_q;
      hs.grant <= grant_q;
      hs.off_clr <= off_clr;
      pointer_load <= m_call;
      pointer_value <= stack_q;
    end
  end
endmodule // dftc_top

// ---- shared/dftc_pkg.sv ----
// package: register map, field positions and types for the dma fifo test control bank
package dftc_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_TEST_REG_FOUR  = 8'h18;
  localparam logic [7:0] IDX_HANDSHAKE      = 8'h19;
  localparam logic [7:0] IDX_FIFO_PORT      = 8'h1A;
  localparam logic [7:0] IDX_BUS_OPTION     = 8'h1B;
  localparam logic [7:0] IDX_CALL_STACK     = 8'h1C;
  localparam logic [7:0] IDX_XFER_OFFSET    = 8'h20;
  localparam logic [7:0] IDX_INT_STATE      = 8'h21;
  localparam logic [7:0] IDX_TEST_REG_TWO   = 8'h16;
  localparam logic [7:0] IDX_TEST_REG_EIGHT = 8'h22;
  localparam logic [7:0] IDX_BYTE_COUNTER   = 8'h24;
  localparam logic [7:0] IDX_NEXT_DATA      = 8'h28;
  localparam logic [7:0] IDX_OFFSET_CNT     = 8'h40;
  localparam logic [7:0] IDX_GROSS_ERROR    = 8'h41;
  // handshake override bits
  localparam int HS_ADDR_STEP  = 7;
  localparam int HS_COUNT_STEP = 6;
  localparam int HS_OFF_RESET  = 5;
  localparam int HS_MASTER     = 4;
  localparam int HS_DIR        = 3;
  localparam int HS_LAST       = 2;
  localparam int HS_REQ        = 1;
  localparam int HS_GRANT      = 0;
  // bus option bits
  localparam int BO_BURST_DIS  = 7;
  localparam int BO_SNOOP_HI   = 6;
  localparam int BO_SNOOP_LO   = 5;
  localparam int BO_TMO_DIS    = 4;
  localparam int BO_FIFO_PAR   = 3;
  localparam int BO_PAR_SENSE  = 2;
  localparam int BO_XFER_TYPE  = 1;
  localparam int BO_BALANCED   = 0;
  // test register two bits
  localparam int T2_FIFO_PAR   = 3;
  localparam int T2_REQ        = 1;
  localparam int T2_GRANT_N    = 0;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [31:0] RST_WORD   = 32'h00000000;
  localparam logic [7:0]  RST_T2     = 8'h20;
  localparam logic [7:0]  T4_MASK    = 8'h07;
  localparam logic [7:0]  T8_MASK    = 8'h0F;
  localparam logic [6:0]  OFFSET_MSK = 7'h7F;
  localparam logic [31:0] ADDR_STEP  = 32'h00000004;
  localparam logic [23:0] CNT_STEP   = 24'h000004;
  localparam int DEPTH = 4;
  localparam int SEL_TIMEOUT_MS = 250;
  localparam longint CLK_HZ = 250000000;
  localparam longint SEL_TIMEOUT_CYC = CLK_HZ / 1000 * SEL_TIMEOUT_MS;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef struct packed {
    logic burst_req;
    logic snoop_hi;
    logic snoop_lo;
    logic xfer_type;
    logic balanced;
    logic host_par;
    logic [3:0] read_par;
  } dftc_pins_s;
  typedef struct packed {
    logic dir;
    logic last;
    logic req;
    logic grant;
    logic off_clr;
  } dftc_hs_s;
endpackage

// ---- tb/dftc_chk.sv ----
// checker: port-level properties of the dma fifo test control bank
`timescale 1ns/10ps
module dftc_chk #(
  parameter longint SEL_TIMEOUT = dftc_pkg::SEL_TIMEOUT_CYC
) (
  input wire logic                 sys_clk,
  input wire logic                 rst,
  input wire logic [31:0]          s_axi_awaddr,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic [31:0]          s_axi_wdata,
  input wire logic [3:0]           s_axi_wstrb,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic                 s_axi_rvalid,
  input wire logic                 sel_active,
  input wire logic                 sel_timeout,
  input wire logic                 gross_error,
  input wire logic                 call_load,
  input wire logic                 pointer_load,
  input wire dftc_pkg::dftc_pins_s pins,
  input wire dftc_pkg::dftc_hs_s   hs
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // only writes whose address and data are taken together are judged
  wire         wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire [7:0]   wd    = s_axi_wdata[7:0];
  wire         hs_w  = wr_go && s_axi_wstrb[0] && s_axi_awaddr[9:2] == dftc_pkg::IDX_HANDSHAKE;
  wire         op_w  = wr_go && s_axi_wstrb[0] && s_axi_awaddr[9:2] == dftc_pkg::IDX_BUS_OPTION;
  logic        bdis_q, tdis_q, evp_q;
  logic [31:0] act_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {bdis_q, tdis_q, evp_q} <= 3'h0;
      act_q <= 32'h0;
    end else begin
      if (op_w) {bdis_q, tdis_q, evp_q} <= {wd[7], wd[4], wd[2]};
      act_q <= sel_active ? act_q + 32'h1 : 32'h0;
    end
  end
  a_dir_set: assert property (hs_w && wd[3] && wd[4] |-> ##[1:3] hs.dir)
    else $error("direction not asserted");
  a_dir_clear: assert property (hs_w && wd[3] && !wd[4] |-> ##[1:3] !hs.dir)
    else $error("direction not deasserted");
  a_last_pulse: assert property (hs_w && wd[2] && wd[4] |-> ##[1:3] hs.last ##[1:3] !hs.last)
    else $error("end marker not pulsed");
  a_req_assert: assert property (hs_w && wd[1] && wd[4] |-> ##[1:3] hs.req)
    else $error("request not asserted");
  a_grant_assert: assert property (hs_w && wd[0] && wd[4] |-> ##[1:3] hs.grant)
    else $error("grant not asserted");
  a_offclr_write: assert property (hs_w && wd[5] |-> ##[1:3] hs.off_clr)
    else $error("offset clear missing after write");
  a_gross_clear: assert property ($rose(gross_error) |-> ##[1:6] hs.off_clr)
    else $error("offset clear missing after gross error");
  a_burst_block: assert property (bdis_q [*3] |-> !pins.burst_req)
    else $error("burst requested while disabled");
  a_tmo_off: assert property (tdis_q [*3] |-> !sel_timeout)
    else $error("timeout while disabled");
  a_tmo_quiet: assert property (!sel_active [*8] |-> !sel_timeout)
    else $error("timeout without selection");
  a_tmo_early: assert property ($rose(sel_timeout) |-> act_q >= SEL_TIMEOUT)
    else $error("timeout too early");
  a_read_par: assert property (s_axi_rvalid |-> pins.read_par == ({~^s_axi_rdata[31:24],
    ~^s_axi_rdata[23:16], ~^s_axi_rdata[15:8], ~^s_axi_rdata[7:0]} ^ {4{evp_q}}))
    else $error("host parity wrong");
  a_ptr_load: assert property ($rose(pointer_load) |-> $past(call_load, 3))
    else $error("pointer load without call");
  cover property (hs.last);
  cover property ($rose(sel_timeout));
  cover property (pins.burst_req);
endmodule // dftc_chk

bind dftc_top dftc_chk #(.SEL_TIMEOUT(SEL_TIMEOUT)) dftc_chk_inst (.sys_clk, .rst,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_wready, .s_axi_rdata, .s_axi_rvalid, .sel_active, .sel_timeout, .gross_error,
  .call_load, .pointer_load, .pins, .hs);

// ---- tb/dftc_top_tb.sv ----
// testbench: axi4-lite scenarios for the dma fifo test control bank
`timescale 1ns/10ps
module dftc_top_tb;
  logic sys_clk, rst, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic bus_master, sync_mode, burst_ok, host_cycle_req, gross_error, core_move, sel_active;
  logic call_load, mem_move, sel_timeout, pointer_load;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, return_addr, pointer_value, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  dftc_pkg::dftc_pins_s pins;
  dftc_pkg::dftc_hs_s hs;
  int err_total, n_compared, cyc;
  localparam logic [7:0] HS = dftc_pkg::IDX_HANDSHAKE, OPT = dftc_pkg::IDX_BUS_OPTION;
  localparam logic [7:0] T4 = dftc_pkg::IDX_TEST_REG_FOUR, OFS = dftc_pkg::IDX_XFER_OFFSET;
  // short selection timeout keeps the run brief
  dftc_top #(.SEL_TIMEOUT(16)) dftc_top_inst (.sys_clk, .rst, .clk_en, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus_master, .sync_mode,
    .burst_ok, .host_cycle_req, .gross_error, .core_move, .sel_active, .call_load, .mem_move,
    .return_addr, .sel_timeout, .pointer_load, .pointer_value, .pins, .hs);
  task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= {22'h0, i, 2'h0};
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] i);
    @(posedge sys_clk);
    s_axi_araddr <= {22'h0, i, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic rc(input string nm, input logic [7:0] i, input logic [31:0] e);
    rd(i);
    ck(nm, e, v);
  endtask
  // inputs cross two sync flops before they act, so settle four cycles
  task automatic w4;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic t_reset;
    rc("hs", HS, 32'h0);
    rc("opt", OPT, 32'h0);
    ck("rpar", 32'hF, 32'(pins.read_par));
    rc("ist", dftc_pkg::IDX_INT_STATE, 32'h0);
    rd(8'h30);
    ck("resp", 32'(dftc_pkg::RESP_SLVERR), 32'(r));
    ck("unmapped", 32'h0, v);
    wr(OFS, 32'hFF);
    rc("ofs", OFS, 32'h7F);
  endtask
  task automatic t_fifo;
    for (int l = 0; l < 4; l++) begin
      wr(T4, 32'(4 + l));
      wr(OPT, 32'(l % 2) << 3);
      wr(dftc_pkg::IDX_FIFO_PORT, 32'(8'h31 * (l + 1)));
    end
    for (int l = 3; l >= 0; l--) begin
      wr(T4, 32'(4 + l));
      rc("fifo", dftc_pkg::IDX_FIFO_PORT, 32'(8'h31 * (l + 1)));
      rd(dftc_pkg::IDX_TEST_REG_TWO);
      ck("fpar", 32'(l % 2), 32'(v[3]));
    end
    wr(T4, 32'h0);
    rc("fifo_off", dftc_pkg::IDX_FIFO_PORT, 32'h0);
  endtask
  task automatic t_step;
    wr(dftc_pkg::IDX_NEXT_DATA, 32'h100);
    wr(HS, 32'h80);
    rc("next", dftc_pkg::IDX_NEXT_DATA, 32'h104);
    wr(dftc_pkg::IDX_BYTE_COUNTER, 32'hFFFFFFFF);
    rc("count", dftc_pkg::IDX_BYTE_COUNTER, 32'hFFFFFF);
    wr(dftc_pkg::IDX_BYTE_COUNTER, 32'h10);
    wr(HS, 32'h40);
    rc("count", dftc_pkg::IDX_BYTE_COUNTER, 32'hC);
    rc("hs", HS, 32'h0);
  endtask
  task automatic t_hs;
    wr(HS, 32'h10);
    wr(HS, 32'h18);
    w4;
    ck("dir", 1, 32'(hs.dir));
    wr(HS, 32'h1F);
    rc("hs", HS, 32'h18);
    wr(HS, 32'h0);
    wr(HS, 32'h8);
    w4;
    ck("dir", 0, 32'(hs.dir));
  endtask
  task automatic t_opt;
    {bus_master, sync_mode, burst_ok, host_cycle_req} <= 4'hF;
    wr(OPT, 32'hC7);
    w4;
    ck("burst", 0, 32'(pins.burst_req));
    ck("snoop", 2, 32'({pins.snoop_hi, pins.snoop_lo}));
    ck("xtype", 1, 32'(pins.xfer_type));
    ck("bal", 1, 32'(pins.balanced));
    ck("hpar", 1, 32'(pins.host_par));
    rc("opt", OPT, 32'hC7);
    ck("rpar", 32'h1, 32'(pins.read_par));
    wr(dftc_pkg::IDX_TEST_REG_EIGHT, 32'h1);
    w4;
    ck("snoop", 3, 32'({pins.snoop_hi, pins.snoop_lo}));
    wr(OPT, 32'h20);
    host_cycle_req <= 1'h0;
    w4;
    ck("burst", 1, 32'(pins.burst_req));
    ck("snoop", 0, 32'({pins.snoop_hi, pins.snoop_lo}));
    wr(dftc_pkg::IDX_TEST_REG_EIGHT, 32'h0);
    wr(OPT, 32'h0);
  endtask
  task automatic t_tmo;
    sel_active <= 1'h1;
    repeat (22) @(posedge sys_clk);
    ck("tmo", 1, 32'(sel_timeout));
    wr(OPT, 32'h10);
    w4;
    ck("tmo", 0, 32'(sel_timeout));
    sel_active <= 1'h0;
    wr(OPT, 32'h0);
  endtask
  task automatic t_stack;
    return_addr <= 32'h12345678;
    call_load <= 1'h1;
    repeat (6) @(posedge sys_clk);
    call_load <= 1'h0;
    rc("stack", dftc_pkg::IDX_CALL_STACK, 32'h12345678);
    ck("ptr", 32'h12345678, pointer_value);
    wr(dftc_pkg::IDX_CALL_STACK, 32'hCAFE0004);
    rc("stack", dftc_pkg::IDX_CALL_STACK, 32'hCAFE0004);
    mem_move <= 1'h1;
    w4;
    mem_move <= 1'h0;
  endtask
  task automatic t_offset;
    core_move <= 1'h1;
    w4;
    core_move <= 1'h0;
    wr(HS, 32'h20);
    rc("ofs", OFS, 32'h0);
    gross_error <= 1'h1;
    w4;
    rd(HS);
    ck("offset_reset", 1, 32'(v[5]));
    gross_error <= 1'h0;
    w4;
    rd(HS);
    ck("offset_reset", 0, 32'(v[5]));
    rc("resid", dftc_pkg::IDX_OFFSET_CNT, 32'h74);
  endtask
  task automatic report_and_stop;
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_total++;
      report_and_stop;
    end
  end
  initial begin
    {rst, clk_en, s_axi_wstrb} = 6'h3F;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {bus_master, sync_mode, burst_ok, host_cycle_req, gross_error} = 5'h0;
    {core_move, sel_active, call_load, mem_move} = 4'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, return_addr} = 128'h0;
    {err_total, n_compared, cyc} = 96'h0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    t_reset;
    t_fifo;
    t_step;
    t_hs;
    t_opt;
    t_tmo;
    t_stack;
    t_offset;
    report_and_stop;
  end
endmodule // dftc_top_tb
